//--- dv/isa_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host bus model
// ****************************************
module isa_host_model
  import isa_host_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              chrdy_oe,
  output isa_host_pkg::isa_ctl_s isa,
  output logic [15:0]            sd,
  output logic                   stuck
);
  int n;
  initial begin
    isa = '{la: 7'h00, sa: 17'h00000, ale: 1'b0, default: 1'b1};
    sd = 16'h0f0f;
    stuck = 1'b0;
  end
  task automatic cycle(input logic mem, input logic wr, input logic rf, input logic ae,
                       input logic [23:0] a, input logic bhe_n, input logic [15:0] d);
    @(posedge clk);
    isa.aen <= ae;
    isa.refresh_n <= ~rf;
    isa.la <= a[23:17];
    isa.sa <= a[16:0];
    isa.sbhe_n <= bhe_n;
    isa.ale <= 1'b1;
    sd <= wr ? d : ~sd;
    // ale stands long enough to pass the pin filter inside the block
    repeat (4) @(posedge clk);
    // upper lines are junk once ale falls, so a stale latch shows
    isa.ale <= 1'b0;
    isa.la <= ~a[23:17];
    isa.memr_n <= ~(mem & ~wr);
    isa.memw_n <= ~(mem & wr);
    isa.ior_n <= ~(~mem & ~wr);
    isa.iow_n <= ~(~mem & wr);
    n = 0;
    repeat (12) @(posedge clk);
    while (chrdy_oe === 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    if (n >= 64) stuck <= 1'b1;
    isa.memr_n <= 1'b1;
    isa.memw_n <= 1'b1;
    isa.ior_n <= 1'b1;
    isa.iow_n <= 1'b1;
    repeat (6) @(posedge clk);
    isa.aen <= 1'b1;
    isa.refresh_n <= 1'b1;
    sd <= ~sd;
  endtask
endmodule

//--- dv/isa_host_side_tb.sv
`timescale 1ns/1ps
module isa_host_side_tb;
  import isa_host_pkg::*;
  localparam logic [23:0] MB = 24'h0d0000;
  localparam logic [15:0] IB = 16'h03e0;
  logic clk = 1'b0, rst_n = 1'b0, pok = 1'b1, clr = 1'b0, dack_n = 1'b1;
  logic dma_mode = 1'b0, bypass = 1'b0, mem16 = 1'b0, io16 = 1'b0, ready = 1'b1;
  logic dma_req = 1'b0, supply_ok = 1'b0;
  logic [7:0] card_irq = 8'h00;
  logic [15:0] rd_data = 16'h0000;
  isa_ctl_s isa;
  access_s acc, got;
  logic [15:0] sd_in, sd_out, wr_data, rdat;
  logic [1:0] sd_oe;
  logic mcs, iocs, chrdy, zws, tc, tick, stuck;
  logic [7:0] irq_out, irq_oe, irq_in;
  logic [5:0] seen;
  int bad_count = 0, samples_checked = 0, nvalid, n;
  always #2.5 clk = ~clk;
  // released irq lines float high; dack comes from the host in dma mode
  assign irq_in = (irq_oe & irq_out) | (~irq_oe & {1'b1, dack_n, 6'h3f});
  isa_host_side #(.MEM_BASE(MB), .IO_BASE(IB)) uut (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .SYSTEM_POWER_OK_IN(pok), .ISA_IN(isa),
    .SD_IN(sd_in), .SD_OUT(sd_out), .SD_OE_OUT(sd_oe), .MEMCS16_OE_OUT(mcs),
    .IOCS16_OE_OUT(iocs), .CHRDY_OE_OUT(chrdy), .ZWS_OE_OUT(zws), .IRQ_IN(irq_in),
    .IRQ_OUT(irq_out), .IRQ_OE_OUT(irq_oe), .SUPPLY_OK_SIGNAL_IN(supply_ok),
    .DMA_MODE_IN(dma_mode), .BYPASS_SYNTH_IN(bypass), .MEM16_IN(mem16), .IO16_IN(io16),
    .READY_IN(ready), .CARD_IRQ_IN(card_irq), .DMA_REQ_IN(dma_req), .RD_DATA_IN(rd_data),
    .WR_DATA_OUT(wr_data), .ACCESS_OUT(acc), .TC_OUT(tc), .SOCK_TICK_OUT(tick));
  isa_host_model host (.clk(clk), .chrdy_oe(chrdy), .isa(isa), .sd(sd_in), .stuck(stuck));
  // ****************************************
  // sticky monitor, valid is only a pulse
  // ****************************************
  always @(posedge clk) begin
    if (clr) begin
      seen <= '0;
      nvalid <= 0;
    end else begin
      seen <= seen | {zws, chrdy, iocs, mcs, sd_oe};
      if (acc.valid === 1'b1) begin
        got <= acc;
        nvalid <= nvalid + 1;
      end
      if (sd_oe === 2'b11) rdat <= sd_out;
    end
  end
  task automatic check(input string what, input logic [31:0] sv, input logic [31:0] ev);
    samples_checked++;
    if (sv !== ev) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, ev, sv);
    end
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic start;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic t_io_read;
    start;
    io16 <= 1'b1;
    rd_data <= 16'ha55a;
    host.cycle(1'b0, 1'b0, 1'b0, 1'b0, {8'h00, IB}, 1'b0, 16'h0000);
    hold(4);
    check("io count", nvalid, 1);
    check("io kind", {got.is_mem, got.is_write}, 2'b00);
    check("io16 select", seen[3], 1'b1);
    check("io stretch", {seen[4], stuck}, 2'b10);
    check("read lanes", seen[1:0], 2'b11);
    check("read data", rdat, 16'ha55a);
    check("bus idle", sd_oe, 2'b00);
    $display("test io read done");
  endtask
  task automatic t_mem_write;
    start;
    mem16 <= 1'b1;
    host.cycle(1'b1, 1'b1, 1'b0, 1'b0, MB | 24'h000124, 1'b0, 16'h3cc3);
    hold(4);
    check("mem kind", {nvalid[1:0], got.is_mem, got.is_write}, 4'h7);
    check("mem addr", got.addr, MB | 24'h000124);
    check("write data", wr_data, 16'h3cc3);
    check("mem16 select", seen[2], 1'b1);
    check("zero wait", {seen[5], seen[4]}, 2'b10);
    check("no drive on write", seen[1:0], 2'b00);
    $display("test mem write done");
  endtask
  task automatic t_lanes;
    logic [1:0] exp [3] = '{2'b11, 2'b10, 2'b01};
    for (int i = 0; i < 3; i++) begin
      start;
      host.cycle(1'b1, 1'b0, 1'b0, 1'b0, {MB[23:1], i == 1}, i == 2, 16'h0000);
      hold(4);
      check("lanes", {got.hi_byte, got.lo_byte}, exp[i]);
    end
    $display("test lanes done");
  endtask
  task automatic t_refused;
    start;
    host.cycle(1'b1, 1'b0, 1'b1, 1'b0, MB, 1'b0, 16'h0000);
    hold(4);
    check("refresh", {nvalid[1:0], seen[1:0]}, 4'h0);
    start;
    host.cycle(1'b0, 1'b0, 1'b0, 1'b1, {8'h00, IB}, 1'b0, 16'h0000);
    hold(4);
    check("aen io", nvalid, 0);
    $display("test refused done");
  endtask
  task automatic t_dma;
    start;
    dma_mode <= 1'b1;
    dma_req <= 1'b1;
    supply_ok <= 1'b1;
    hold(8);
    check("dack input", irq_oe[6], 1'b0);
    check("dreq out", {irq_oe[7], irq_out[7]}, 2'b11);
    check("term count", tc, 1'b1);
    dack_n <= 1'b0;
    hold(6);
    host.cycle(1'b0, 1'b1, 1'b0, 1'b1, {8'h00, IB}, 1'b0, 16'h1234);
    hold(4);
    check("dma io", nvalid, 1);
    dack_n <= 1'b1;
    dma_mode <= 1'b0;
    dma_req <= 1'b0;
    supply_ok <= 1'b0;
    $display("test dma done");
  endtask
  task automatic t_irq;
    start;
    card_irq <= 8'h01;
    hold(8);
    check("irq line", {irq_oe[0], irq_out[0]}, 2'b11);
    card_irq <= 8'h00;
    $display("test irq done");
  endtask
  task automatic t_tick;
    for (int b = 0; b < 2; b++) begin
      bypass <= b[0];
      hold(8);
      n = 0;
      repeat (800) begin
        @(posedge clk);
        if (tick === 1'b1) n++;
      end
      check("tick rate", n >= 99 && n <= 101, 1);
    end
    $display("test tick done");
  endtask
  task automatic t_reset;
    start;
    pok <= 1'b0;
    card_irq <= 8'h01;
    dma_mode <= 1'b1;
    supply_ok <= 1'b1;
    hold(3);
    check("reset outs", {sd_oe, mcs, iocs, chrdy, zws, irq_oe, tc}, 0);
    pok <= 1'b1;
    card_irq <= 8'h00;
    dma_mode <= 1'b0;
    supply_ok <= 1'b0;
    hold(8);
    $display("test reset done");
  endtask
  task automatic complete_run;
    // a host cycle that ran out of its wait bound fails the run
    check("host stall", stuck, 1'b0);
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    hold(6);
    rst_n <= 1'b1;
    hold(8);
    t_io_read;
    t_mem_write;
    t_lanes;
    t_refused;
    t_dma;
    t_irq;
    t_tick;
    t_reset;
    complete_run;
  end
endmodule

//--- rtl/isa_host_pkg.sv
package isa_host_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SOCK_CLK_MHZ     = 25;
  // 200 MHz / 25 MHz = 8 core cycles per socket timing period
  localparam int unsigned SOCK_DIV         = CLK_MHZ / SOCK_CLK_MHZ;
  // 14.318 MHz oscillator, scaled by 1000; the phase accumulator steps in MHz and does not use it
  localparam int unsigned OSC_KHZ          = 14318;
  localparam int unsigned SOCK_KHZ         = 25000;
  localparam int unsigned WAIT_CYCLES      = 4;
  localparam int unsigned SYNC_STAGES      = 3;

  // ****************************************
  // irq pin index positions
  // ****************************************
  localparam int unsigned IRQ_W            = 8;
  localparam int unsigned IRQ_DACK_BIT     = 6;
  localparam int unsigned IRQ_DREQ_BIT     = 7;
  // low six lines map to irq 14, 11, 7, 5, 4, 3

  // ****************************************
  // bus carriers
  // ****************************************
  typedef struct packed {
    logic [23:17] la;
    logic [16:0]  sa;
    logic         sbhe_n;
    logic         ior_n;
    logic         iow_n;
    logic         memr_n;
    logic         memw_n;
    logic         refresh_n;
    logic         ale;
    logic         aen;
  } isa_ctl_s;

  typedef struct packed {
    logic        valid;
    logic        is_mem;
    logic        is_write;
    logic [23:0] addr;
    logic        hi_byte;
    logic        lo_byte;
  } access_s;

  typedef enum logic [1:0] {
    W_BYTE_LO,
    W_BYTE_HI,
    W_WORD
  } width_e;

endpackage

//--- rtl/isa_host_side.sv
`timescale 1ns/1ps
module isa_host_side
  import isa_host_pkg::*;
#(
  parameter logic [23:0] MEM_BASE  = 24'h0d0000,
  parameter logic [23:0] MEM_MASK  = 24'hff0000,
  parameter logic [15:0] IO_BASE   = 16'h03e0,
  parameter logic [15:0] IO_MASK   = 16'hfffe,
  parameter int unsigned WAIT_N    = WAIT_CYCLES
) (
  // clock and reset
  input  wire logic             MCLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic             SYSTEM_POWER_OK_IN,
  // isa control and address
  input  wire isa_host_pkg::isa_ctl_s ISA_IN,
  // isa data
  input  wire logic [15:0]      SD_IN,
  output logic [15:0]           SD_OUT,
  output logic [1:0]            SD_OE_OUT,
  // acknowledges
  output logic                  MEMCS16_OE_OUT,
  output logic                  IOCS16_OE_OUT,
  output logic                  CHRDY_OE_OUT,
  output logic                  ZWS_OE_OUT,
  // interrupt and dma pins
  input  wire logic [IRQ_W-1:0] IRQ_IN,
  output logic [IRQ_W-1:0]      IRQ_OUT,
  output logic [IRQ_W-1:0]      IRQ_OE_OUT,
  input  wire logic             SUPPLY_OK_SIGNAL_IN,
  // user side configuration and events
  input  wire logic             DMA_MODE_IN,
  input  wire logic             BYPASS_SYNTH_IN,
  input  wire logic             MEM16_IN,
  input  wire logic             IO16_IN,
  input  wire logic             READY_IN,
  input  wire logic [IRQ_W-1:0] CARD_IRQ_IN,
  input  wire logic             DMA_REQ_IN,
  input  wire logic [15:0]      RD_DATA_IN,
  output logic [15:0]           WR_DATA_OUT,
  output isa_host_pkg::access_s ACCESS_OUT,
  output logic                  TC_OUT,
  output logic                  SOCK_TICK_OUT
);
  // the wait counter is eight bits wide and a zero count would skip the stretch
  if (WAIT_N < 1 || WAIT_N > 255) begin : g_wait_range
    $error("WAIT_N out of range");
  end

  // ****************************************
  // reset from power-ok
  // ****************************************
  logic rst_n;
  assign rst_n = RST_N_IN & SYSTEM_POWER_OK_IN;

  // ****************************************
  // input synchronisers, three stages
  // ****************************************
  localparam int unsigned SW = $bits(isa_ctl_s) + 3;
  logic [SW-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= {ISA_IN, IRQ_IN[IRQ_DACK_BIT], SUPPLY_OK_SIGNAL_IN, 1'b1};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change is only taken once the last two stages agree
  logic [SW-1:0] f_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) f_q <= '1;
    else f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
  end

  isa_ctl_s bus;
  logic     dack_n, tc_in;
  assign bus    = f_q[SW-1:3];
  assign dack_n = f_q[2];
  assign tc_in  = f_q[1];

  // ****************************************
  // address latch and decode
  // ****************************************
  logic [23:17] la_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) la_q <= '0;
    else if (bus.ale) la_q <= bus.la;
  end

  logic [23:0] maddr;
  logic        mem_hit, io_hit, dreq_q;
  assign maddr   = {la_q, bus.sa};
  assign mem_hit = ((maddr & MEM_MASK) == (MEM_BASE & MEM_MASK));
  assign io_hit  = ((bus.sa[15:0] & IO_MASK) == (IO_BASE & IO_MASK));

  // byte lanes; an 8-bit host keeps SBHE high so only one lane is used
  function automatic width_e lane(input logic sbhe_n, input logic a0);
    if (!sbhe_n && !a0) lane = W_WORD;
    else if (!sbhe_n) lane = W_BYTE_HI;
    else lane = W_BYTE_LO;
  endfunction

  width_e w;
  assign w = lane(bus.sbhe_n, bus.sa[0]);

  logic dma_ok, io_en, mem_rd, mem_wr, io_rd, io_wr, cyc;
  assign dma_ok = DMA_MODE_IN & dreq_q & !dack_n;
  assign io_en  = !bus.aen | dma_ok;
  assign mem_rd = !bus.memr_n & bus.refresh_n & mem_hit;
  assign mem_wr = !bus.memw_n & bus.refresh_n & mem_hit;
  assign io_rd  = !bus.ior_n & io_en & (io_hit | dma_ok);
  assign io_wr  = !bus.iow_n & io_en & (io_hit | dma_ok);
  assign cyc    = mem_rd | mem_wr | io_rd | io_wr;

  // ****************************************
  // cycle control
  // ****************************************
  typedef enum logic [1:0] {IDLE, WAIT, DONE} st_e;
  st_e        st_q;
  logic [7:0] wcnt_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= IDLE;
      wcnt_q <= '0;
    end else begin
      case (st_q)
        IDLE: if (cyc) begin
          st_q   <= (READY_IN && mem_rd | mem_wr) ? DONE : WAIT;
          wcnt_q <= 8'(WAIT_N);
        end
        WAIT: begin
          if (wcnt_q != 8'h00) wcnt_q <= wcnt_q - 8'h01;
          else if (READY_IN) st_q <= DONE;
        end
        DONE: if (!cyc) st_q <= IDLE;
        default: st_q <= IDLE;
      endcase
    end
  end

  // ****************************************
  // bus outputs
  // ****************************************
  logic rd_any;
  assign rd_any = (mem_rd | io_rd) & (st_q != IDLE);
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      SD_OUT         <= '0;
      SD_OE_OUT      <= '0;
      MEMCS16_OE_OUT <= 1'b0;
      IOCS16_OE_OUT  <= 1'b0;
      CHRDY_OE_OUT   <= 1'b0;
      ZWS_OE_OUT     <= 1'b0;
      WR_DATA_OUT    <= '0;
      ACCESS_OUT     <= '0;
    end else begin
      MEMCS16_OE_OUT <= mem_hit & MEM16_IN & bus.refresh_n;
      IOCS16_OE_OUT  <= io_hit & IO16_IN & io_en;
      CHRDY_OE_OUT   <= cyc & (st_q != DONE) & !(st_q == IDLE && READY_IN);
      ZWS_OE_OUT     <= (mem_rd | mem_wr) & READY_IN & (st_q != WAIT);
      // high byte from odd address with SBHE low is copied to the low lane as well
      SD_OUT <= (w == W_BYTE_HI && bus.sa[0]) ? {RD_DATA_IN[15:8], RD_DATA_IN[15:8]}
                : RD_DATA_IN;
      SD_OE_OUT[0] <= rd_any & (w != W_BYTE_HI || bus.sa[0]);
      SD_OE_OUT[1] <= rd_any & (w != W_BYTE_LO);
      if ((mem_wr | io_wr) && st_q == IDLE) begin
        WR_DATA_OUT <= SD_IN;
      end
      ACCESS_OUT.valid    <= cyc & (st_q == IDLE);
      ACCESS_OUT.is_mem   <= mem_rd | mem_wr;
      ACCESS_OUT.is_write <= mem_wr | io_wr;
      ACCESS_OUT.addr     <= (mem_rd | mem_wr) ? maddr : {8'h00, bus.sa[15:0]};
      ACCESS_OUT.hi_byte  <= (w != W_BYTE_LO);
      ACCESS_OUT.lo_byte  <= (w != W_BYTE_HI);
    end
  end

  // ****************************************
  // interrupts and dma pins
  // ****************************************
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT    <= '0;
      IRQ_OE_OUT <= '0;
      dreq_q     <= 1'b0;
      TC_OUT     <= 1'b0;
    end else begin
      IRQ_OUT    <= CARD_IRQ_IN;
      IRQ_OE_OUT <= {IRQ_W{1'b1}};
      dreq_q     <= DMA_MODE_IN & DMA_REQ_IN;
      if (DMA_MODE_IN) begin
        IRQ_OE_OUT[IRQ_DACK_BIT] <= 1'b0;
        IRQ_OUT[IRQ_DREQ_BIT]    <= DMA_REQ_IN;
      end
      TC_OUT <= DMA_MODE_IN & tc_in;
    end
  end

  // ****************************************
  // socket timing tick
  // ****************************************
  // no oscillator pin reaches this block, so the synthesiser is a phase
  // accumulator stepping the socket rate against the core rate
  logic [15:0] acc_q;
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      acc_q         <= '0;
      SOCK_TICK_OUT <= 1'b0;
    end else begin
      if (BYPASS_SYNTH_IN) begin
        acc_q         <= (acc_q >= 16'(SOCK_DIV - 1)) ? 16'h0000 : acc_q + 16'h0001;
        SOCK_TICK_OUT <= (acc_q == 16'h0000);
      end else begin
        acc_q <= (acc_q + 16'(SOCK_CLK_MHZ) >= 16'(CLK_MHZ))
                 ? acc_q + 16'(SOCK_CLK_MHZ) - 16'(CLK_MHZ) : acc_q + 16'(SOCK_CLK_MHZ);
        SOCK_TICK_OUT <= (acc_q + 16'(SOCK_CLK_MHZ) >= 16'(CLK_MHZ));
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  refresh_blocks_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    !bus.refresh_n |=> !MEMCS16_OE_OUT && !ZWS_OE_OUT)
    else $error("memory answered in refresh");
  aen_blocks_io_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    bus.aen && !dma_ok |=> !IOCS16_OE_OUT && (!ACCESS_OUT.valid || ACCESS_OUT.is_mem))
    else $error("io taken with aen");
  memcs_follows_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    mem_hit && MEM16_IN && bus.refresh_n |=> MEMCS16_OE_OUT) else $error("memcs16 missing");
  iocs_follows_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    io_hit && IO16_IN && !bus.aen |=> IOCS16_OE_OUT) else $error("iocs16 missing");
  chrdy_release_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    !cyc |=> !CHRDY_OE_OUT) else $error("ready held without cycle");
  data_float_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    !(mem_rd || io_rd) |=> SD_OE_OUT == 2'b00) else $error("data driven outside read");
  dack_input_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    DMA_MODE_IN |=> !IRQ_OE_OUT[IRQ_DACK_BIT]) else $error("dack pin driven");
  dreq_drive_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    DMA_MODE_IN && DMA_REQ_IN |=> IRQ_OUT[IRQ_DREQ_BIT]) else $error("dreq not driven");
  zws_no_wait_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    st_q == WAIT |=> !ZWS_OE_OUT) else $error("zero wait during wait");
  tc_gate_a: assert property (@(posedge MCLK_IN) disable iff (!rst_n)
    !DMA_MODE_IN |=> !TC_OUT) else $error("tc outside dma");

endmodule
